// ===== logic/dpc_port_ctrl.sv
`timescale 1ns/1ps
`include "dpc_params.svh"
// Notes on behaviour
// RQ1: master select high makes the part drive both collision flags, low makes them inputs.
// RQ2: on a slave, a low collision flag input blocks that port's writes.
// RQ3: master flags collision only when both selects are low and addresses match.
// RQ4: the port whose address and enable settled later gets the low flag.
// RQ5: both collision flags are never low at the same time.
// RQ6: writes are ignored while the master drives that port's flag low.
// RQ7: arbitration looks at selects and addresses only, never read or write.
// RQ8: right port writing the lower mailbox address sets the left interrupt.
// RQ9: left port access of that address with select and output enable clears it.
// RQ10: left port writing the top address sets the right interrupt.
// RQ11: right port reading the top address clears the right interrupt.
// RQ12: both mailbox locations stay ordinary byte storage.
// RQ13: eight token flags on the low three address bits; data bit zero writes.
// RQ14: token access holds memory select high and token select low.
// RQ15: a free token reads one on both ports; a claimer then reads zero.
// RQ16: a zero from the non-holder changes nothing but stays pending.
// RQ17: holder writing one passes the token to a pending requester, else frees it.
// RQ18: system logic may hold a slave's collision input low to block writes.
// RQ19: exactly one master arbitrates; other parts are slaves taking its flags.
// RQ20: address and select stay valid until the collision flag settles before writing.
// RQ21: in depth expansion the low-active collision flags are combined by AND.
// RQ22: a token read is held until token select or output enable goes inactive.
// RQ23: same-cycle requests from both ports resolve by a fixed tie-break.

module dpc_port_ctrl #(
  parameter int  NBANKS     = 1,
  parameter bit  MASTER_SEL = 1'b1
) (
  input  wire logic                       clock_i,
  input  wire logic                       rst_i,
  // user side
  input  wire logic                       req_i,
  input  wire dpc_pkg::dpc_cmd_t          cmd_i,
  input  wire logic [`DPC_ADDR_W-1:0]     addr_i,
  input  wire logic [`DPC_DATA_W-1:0]     wdata_i,
  input  wire logic                       inhibit_i,
  output logic                            ready_o,
  output logic                            done_o,
  output logic                            collision_o,
  output logic [`DPC_DATA_W-1:0]          rdata_o,
  output logic                            mailbox_irq_o,
  // memory port pins
  output logic [`DPC_ADDR_W-1:0]          addr_o,
  output logic                            ce_n_o,
  output logic                            token_space_select_n_o,
  output logic                            oe_n_o,
  output logic                            rw_n_o,
  output logic [`DPC_DATA_W-1:0]          data_o,
  output logic                            data_oe_o,
  input  wire logic [`DPC_DATA_W-1:0]     data_i,
  input  wire logic [NBANKS-1:0]          busy_n_i,
  input  wire logic                       mailbox_irq_n_i,
  output logic                            master_sel_o,
  output logic                            slave_busy_n_o
);

  localparam int SW = NBANKS + 1 + `DPC_DATA_W;
  // setup covers flag settling plus the sync and output latency of the flag path
  localparam logic [3:0] SETUP_LD  =
    4'(`DPC_CYC_UP(`DPC_T_BUSY_NS) + `DPC_SYNC_STAGES + `DPC_OUT_LAT);
  localparam logic [3:0] RSTB_LD   = 4'(`DPC_CYC_UP(`DPC_T_ACC_NS) + `DPC_SYNC_STAGES);
  localparam logic [3:0] WSTB_LD   = 4'(`DPC_CYC_UP(`DPC_T_WP_NS));

  if (NBANKS < 1 || NBANKS > 16) begin : g_chk
    $error("dpc_port_ctrl: NBANKS must be 1 to 16");
  end

  function automatic logic is_write(input dpc_pkg::dpc_cmd_t c);
    return c == dpc_pkg::DPC_CMD_MEM_WR || c == dpc_pkg::DPC_CMD_SEM_WR;
  endfunction

  function automatic logic is_token(input dpc_pkg::dpc_cmd_t c);
    return c == dpc_pkg::DPC_CMD_SEM_RD || c == dpc_pkg::DPC_CMD_SEM_WR;
  endfunction

  // pin inputs
  logic [SW-1:0] sync_q;
  dpc_sync #(
    .W (SW)
  ) u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .d_i     ({busy_n_i, mailbox_irq_n_i, data_i}),
    .init_i  ({{NBANKS{1'b1}}, 1'b1, {`DPC_DATA_W{1'b0}}}),
    .q_o     (sync_q)
  );

  wire [NBANKS-1:0]      busy_n_s = sync_q[SW-1 -: NBANKS];
  wire                   irq_n_s  = sync_q[`DPC_DATA_W];
  wire [`DPC_DATA_W-1:0] data_s   = sync_q[`DPC_DATA_W-1:0];
  wire                   busy_all_n = &busy_n_s; // RQ21

  dpc_pkg::dpc_state_t   state_r;
  dpc_pkg::dpc_cmd_t     cmd_r;
  logic [3:0]            cnt_r;
  logic                  done_r;
  logic                  coll_r;
  logic [`DPC_DATA_W-1:0] rdata_r;
  logic [`DPC_ADDR_W-1:0] addr_r;
  logic                  ce_n_r;
  logic                  tok_n_r;
  logic                  oe_n_r;
  logic                  rw_n_r;
  logic [`DPC_DATA_W-1:0] dout_r;
  logic                  doe_r;
  logic                  msel_r;
  logic                  sbusy_n_r;
  logic                  irq_r;

  wire cnt_zero   = (cnt_r == 4'h0);
  wire wr_cmd     = is_write(cmd_r);
  // a write is dropped if the combined flag is low at the end of setup; inhibit also stops our own writes
  wire wr_blocked = wr_cmd && (!busy_all_n || inhibit_i); // RQ20
  // token writes carry only bit zero, spread so the bus is never half driven
  wire [`DPC_DATA_W-1:0] wdata_sel = is_token(cmd_i) ?
    {`DPC_DATA_W{wdata_i[`DPC_TOKEN_BIT]}} : wdata_i;
  wire [`DPC_ADDR_W-1:0] addr_sel  = is_token(cmd_i) ?
    {{(`DPC_ADDR_W-`DPC_TOKEN_AW){1'b0}}, addr_i[`DPC_TOKEN_AW-1:0]} : addr_i;

  assign ready_o = (state_r == dpc_pkg::DPC_ST_IDLE);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_r <= dpc_pkg::DPC_ST_IDLE;
      cmd_r   <= dpc_pkg::DPC_CMD_MEM_RD;
      cnt_r   <= 4'h0;
      done_r  <= 1'b0;
      coll_r  <= 1'b0;
      rdata_r <= '0;
      addr_r  <= '0;
      ce_n_r  <= 1'b1;
      tok_n_r <= 1'b1;
      oe_n_r  <= 1'b1;
      rw_n_r  <= 1'b1;
      dout_r  <= '0;
      doe_r   <= 1'b0;
    end else begin
      done_r <= 1'b0;
      coll_r <= 1'b0;
      case (state_r)
        dpc_pkg::DPC_ST_IDLE: begin
          if (req_i) begin
            cmd_r   <= cmd_i;
            addr_r  <= addr_sel;
            dout_r  <= wdata_sel;
            ce_n_r  <= is_token(cmd_i);  // RQ14
            tok_n_r <= !is_token(cmd_i); // RQ14
            doe_r   <= is_write(cmd_i);
            cnt_r   <= SETUP_LD - 4'h1;
            state_r <= dpc_pkg::DPC_ST_SETUP;
          end
        end
        dpc_pkg::DPC_ST_SETUP: begin
          if (!cnt_zero) begin
            cnt_r <= cnt_r - 4'h1;
          end else if (wr_blocked) begin
            // lost arbitration: drop the write instead of strobing into a gated port
            ce_n_r  <= 1'b1;
            tok_n_r <= 1'b1;
            doe_r   <= 1'b0;
            coll_r  <= 1'b1;
            done_r  <= 1'b1;
            state_r <= dpc_pkg::DPC_ST_GAP;
          end else begin
            rw_n_r  <= !wr_cmd; // RQ20
            oe_n_r  <= wr_cmd;
            cnt_r   <= wr_cmd ? WSTB_LD - 4'h1 : RSTB_LD - 4'h1;
            state_r <= dpc_pkg::DPC_ST_STROBE;
          end
        end
        dpc_pkg::DPC_ST_STROBE: begin
          if (!cnt_zero) begin
            cnt_r <= cnt_r - 4'h1;
          end else begin
            if (!wr_cmd) begin
              rdata_r <= data_s;
            end
            rw_n_r  <= 1'b1;
            oe_n_r  <= 1'b1;
            state_r <= dpc_pkg::DPC_ST_HOLD;
          end
        end
        dpc_pkg::DPC_ST_HOLD: begin
          // address and data held one cycle past the strobe
          ce_n_r  <= 1'b1;
          tok_n_r <= 1'b1;
          doe_r   <= 1'b0;
          done_r  <= 1'b1;
          state_r <= dpc_pkg::DPC_ST_GAP;
        end
        dpc_pkg::DPC_ST_GAP: begin
          // one idle cycle so a repeated token read reopens the part's latch
          state_r <= dpc_pkg::DPC_ST_IDLE; // RQ22
        end
        default: begin
          state_r <= dpc_pkg::DPC_ST_IDLE;
        end
      endcase
    end
  end

  // cascade pins: one master only, slaves see its combined flag or our inhibit
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      msel_r    <= 1'b0;
      sbusy_n_r <= 1'b1;
      irq_r     <= 1'b0;
    end else begin
      msel_r    <= MASTER_SEL;                // RQ19
      sbusy_n_r <= busy_all_n && !inhibit_i; // RQ18
      irq_r     <= !irq_n_s;
    end
  end

  assign done_o                 = done_r;
  assign collision_o            = coll_r;
  assign rdata_o                = rdata_r;
  assign mailbox_irq_o          = irq_r;
  assign addr_o                 = addr_r;
  assign ce_n_o                 = ce_n_r;
  assign token_space_select_n_o = tok_n_r;
  assign oe_n_o                 = oe_n_r;
  assign rw_n_o                 = rw_n_r;
  assign data_o                 = dout_r;
  assign data_oe_o              = doe_r;
  assign master_sel_o           = msel_r;
  assign slave_busy_n_o         = sbusy_n_r;

  // helper: cycles the current select has been held
  logic [4:0] sel_age_r;
  always_ff @(posedge clock_i) begin
    if (rst_i || (ce_n_r && tok_n_r)) begin
      sel_age_r <= 5'h00;
    end else if (sel_age_r != 5'h1f) begin
      sel_age_r <= sel_age_r + 5'h01;
    end
  end

  a_token_select_pair: assert property (@(posedge clock_i) disable iff (rst_i) // RQ14
    !tok_n_r |-> ce_n_r)
    else $error("token select low while memory select low");

  a_inhibit_blocks: assert property (@(posedge clock_i) disable iff (rst_i) // RQ18
    inhibit_i |=> !sbusy_n_r)
    else $error("slave collision input not held low under inhibit");

  // guard on the previous reset level; the release edge itself still shows the reset value
  a_one_master: assert property (@(posedge clock_i) disable iff (rst_i) // RQ19
    !$past(rst_i) |-> (msel_r == MASTER_SEL))
    else $error("master select pin not at configured value");

  a_settle_write: assert property (@(posedge clock_i) disable iff (rst_i) // RQ20
    $fell(rw_n_r) |-> (5'(SETUP_LD) <= sel_age_r) && $stable(addr_r))
    else $error("write strobe before collision flag could settle");

  a_busy_and_gate: assert property (@(posedge clock_i) disable iff (rst_i) // RQ21
    $fell(rw_n_r) |-> $past(busy_all_n) && $past(!inhibit_i))
    else $error("write strobe with combined collision flag low");

  a_read_reopen: assert property (@(posedge clock_i) disable iff (rst_i) // RQ22
    $rose(oe_n_r) |-> ##1 (tok_n_r && ce_n_r) [*2])
    else $error("selects not released between reads");

endmodule // dpc_port_ctrl

// ===== logic/dpc_params.svh
`ifndef DPC_PARAMS_SVH
`define DPC_PARAMS_SVH

// clock period and rounding of pin times to clock cycles
`define DPC_CLK_NS        20
`define DPC_CYC_UP(ns)    (((ns) + `DPC_CLK_NS - 1) / `DPC_CLK_NS)

// pin timing of the memory part
`define DPC_T_BUSY_NS     25
`define DPC_T_ACC_NS      25
`define DPC_T_WP_NS       25

// pin input synchroniser depth and registered-output latency
`define DPC_SYNC_STAGES   2
`define DPC_OUT_LAT       1

// pin widths
`define DPC_ADDR_W        15
`define DPC_DATA_W        8
`define DPC_TOKEN_BIT     0
`define DPC_TOKEN_AW      3

`endif

// ===== logic/dpc_pkg.sv
package dpc_pkg;

  typedef enum logic [1:0] {
    DPC_CMD_MEM_RD = 2'h0,
    DPC_CMD_MEM_WR = 2'h1,
    DPC_CMD_SEM_RD = 2'h2,
    DPC_CMD_SEM_WR = 2'h3
  } dpc_cmd_t;

  typedef enum logic [4:0] {
    DPC_ST_IDLE   = 5'h01,
    DPC_ST_SETUP  = 5'h02,
    DPC_ST_STROBE = 5'h04,
    DPC_ST_HOLD   = 5'h08,
    DPC_ST_GAP    = 5'h10
  } dpc_state_t;

endpackage

// ===== logic/dpc_sync.sv
`timescale 1ns/1ps
`include "dpc_params.svh"

module dpc_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  input  wire logic [W-1:0] init_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // init_i must be a constant at the instance; reset takes nothing else
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      meta_r <= init_i;
      q_r    <= init_i;
    end else begin
      meta_r <= d_i;
      q_r    <= meta_r;
    end
  end

  assign q_o = q_r;

endmodule // dpc_sync

// ===== verif/dpc_mem_model.sv
`timescale 1ns/1ps
module dpc_mem_model (
  input  wire logic [14:0] addr_i,
  input  wire logic        ce_n_i,
  input  wire logic        tok_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        rw_n_i,
  input  wire logic [7:0]  data_i,
  input  wire logic        ms_i,
  input  wire logic        busy_in_n_i,
  output logic      [7:0]  data_o,
  output logic             busy_n_o,
  output logic             irq_n_o
);
  logic [7:0]  mem [0:32767];
  logic [1:0]  owner [0:7];
  logic [7:0]  pend [1:2];
  logic [14:0] r_addr = 15'h0;
  logic        r_ce_n = 1'b1;
  logic        r_first = 1'b0;
  logic        irq_r_n = 1'b1;
  logic [7:0]  tok_q = 8'h00;
  logic [7:0]  last_q = 8'h00;
  wire         mem_rd = ~ce_n_i & ~oe_n_i;
  wire         tok_rd = ~tok_n_i & ~oe_n_i;
  // only the left port is flagged, so both flags are never low together
  wire         arb_n = ~(~ce_n_i & ~r_ce_n & (addr_i == r_addr) & r_first);
  assign busy_n_o = ms_i ? arb_n : busy_in_n_i;
  // released bus shows the inverse of the last value, never a held copy
  assign #25 data_o = mem_rd ? mem[addr_i] : tok_rd ? tok_q : ~last_q;
  initial begin
    irq_n_o = 1'b1;
    pend[1] = 8'h00;
    pend[2] = 8'h00;
    for (int i = 0; i < 8; i++) owner[i] = 2'h0;
  end
  always @(negedge mem_rd or negedge tok_rd) if (^data_o !== 1'bx) last_q = data_o;
  always @(posedge tok_rd) tok_q = {8{owner[addr_i[2:0]] != 2'h1}};
  always @(posedge mem_rd) if (addr_i == 15'h7ffe) irq_n_o = 1'b1;
  always @(posedge rw_n_i) begin
    if (!ce_n_i && busy_n_o) mem[addr_i] = data_i;
    if (!ce_n_i && busy_n_o && addr_i == 15'h7fff) irq_r_n = 1'b0;
    if (!tok_n_i) tok_wr(2'h1, addr_i[2:0], data_i[0]);
  end
  // me: 1 left, 2 right; owner 0 means free
  task automatic tok_wr(input logic [1:0] me, input logic [2:0] i, input logic b);
    logic [1:0] other;
    other = 2'h3 - me;
    if (!b && owner[i] == 2'h0) owner[i] = me;
    else if (!b && owner[i] == other) pend[me][i] = 1'b1;
    else if (b && owner[i] == me) owner[i] = pend[other][i] ? other : 2'h0;
    if (b) pend[me][i] = 1'b0;
    if (b && owner[i] == other) pend[other][i] = 1'b0;
  endtask
  task automatic right_write(input logic [14:0] a, input logic [7:0] d);
    mem[a] = d;
    if (a == 15'h7ffe) irq_n_o = 1'b0;
  endtask
  task automatic right_read(input logic [14:0] a, output logic [7:0] d);
    d = mem[a];
    if (a == 15'h7fff) irq_r_n = 1'b1;
  endtask
  task automatic right_select(input logic [14:0] a, input logic on);
    // a right select made while the left is already low loses the tie
    r_first = ce_n_i;
    r_addr = a;
    r_ce_n = ~on;
  endtask
  function automatic logic right_flag(input logic [2:0] i);
    return owner[i] != 2'h2;
  endfunction
endmodule // dpc_mem_model

// ===== verif/dpc_port_ctrl_tb.sv
`timescale 1ns/1ps
module dpc_port_ctrl_tb;
  typedef struct packed {
    logic [1:0]  cmd;
    logic [14:0] addr;
    logic [7:0]  wd;
    logic [7:0]  rd;
  } dpc_row_t;
  dpc_row_t          rows [9] = '{
    '{2'h1, 15'h0012, 8'ha5, 8'h00}, '{2'h0, 15'h0012, 8'h00, 8'ha5}, '{2'h1, 15'h7fff, 8'h3c, 8'h00},
    '{2'h0, 15'h7fff, 8'h00, 8'h3c}, '{2'h1, 15'h7ffe, 8'h77, 8'h00}, '{2'h0, 15'h7ffe, 8'h00, 8'h77},
    '{2'h3, 15'h0003, 8'hfe, 8'h00}, '{2'h2, 15'h0003, 8'h00, 8'h00}, '{2'h2, 15'h0004, 8'h00, 8'hff}};
  logic              clock_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              req_i = 1'b0;
  dpc_pkg::dpc_cmd_t cmd_i = dpc_pkg::DPC_CMD_MEM_RD;
  logic [14:0]       addr_i = 15'h0;
  logic [7:0]        wdata_i = 8'h00;
  logic              inhibit_i = 1'b0;
  logic              ready_o, done_o, collision_o, mailbox_irq_o, ce_n, tok_n, oe_n, rw_n, data_oe;
  logic              busy_n, irq_n, ms, sbusy_n, co;
  logic [14:0]       pin_addr;
  logic [7:0]        rdata_o, dout, mdout, rd;
  int                fails = 0;
  int                compares = 0;
  wire  [7:0]        bus = data_oe ? dout : mdout;
  dpc_port_ctrl dut_u (
    .clock_i(clock_i), .rst_i(rst_i), .req_i(req_i), .cmd_i(cmd_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .inhibit_i(inhibit_i), .ready_o(ready_o), .done_o(done_o), .collision_o(collision_o), .rdata_o(rdata_o),
    .mailbox_irq_o(mailbox_irq_o), .addr_o(pin_addr), .ce_n_o(ce_n), .token_space_select_n_o(tok_n),
    .oe_n_o(oe_n), .rw_n_o(rw_n), .data_o(dout), .data_oe_o(data_oe), .data_i(bus), .busy_n_i(busy_n),
    .mailbox_irq_n_i(irq_n), .master_sel_o(ms), .slave_busy_n_o(sbusy_n));
  dpc_mem_model mdl_u (
    .addr_i(pin_addr), .ce_n_i(ce_n), .tok_n_i(tok_n), .oe_n_i(oe_n), .rw_n_i(rw_n), .data_i(bus),
    .ms_i(ms), .busy_in_n_i(sbusy_n), .data_o(mdout), .busy_n_o(busy_n), .irq_n_o(irq_n));
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h0, got}, {7'h0, exp});
  endtask
  task automatic conclude;
    if (fails == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one whole transfer; done is sampled in the cycle that it stands
  task automatic xfer(input logic [1:0] c, input logic [14:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    req_i <= 1'b1;
    cmd_i <= dpc_pkg::dpc_cmd_t'(c);
    addr_i <= a;
    wdata_i <= d;
    do @(posedge clock_i); while (ready_o !== 1'b1);
    req_i <= 1'b0;
    do begin
      @(posedge clock_i);
      n++;
    end while (done_o !== 1'b1 && n < 40);
    chk1(done_o, 1'b1);
    rd = rdata_o;
    co = collision_o;
  endtask
  always #10 clock_i = ~clock_i;
  initial begin
    #60000;
    fails++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge clock_i);
    chk1(ce_n, 1'b1);
    chk1(done_o, 1'b0);
    rst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    chk1(ms, 1'b1);
    foreach (rows[i]) begin
      xfer(rows[i].cmd, rows[i].addr, rows[i].wd);
      chk1(co, 1'b0);
      if (!rows[i].cmd[0]) chk8(rd, rows[i].rd);
    end
    chk1(mdl_u.irq_r_n, 1'b0);
    mdl_u.right_read(15'h7fff, rd);
    chk8(rd, 8'h3c);
    chk1(mdl_u.irq_r_n, 1'b1);
    mdl_u.right_write(15'h7ffe, 8'h5a);
    repeat (5) @(posedge clock_i);
    chk1(mailbox_irq_o, 1'b1);
    xfer(2'h0, 15'h7ffe, 8'h00);
    chk8(rd, 8'h5a);
    repeat (5) @(posedge clock_i);
    chk1(mailbox_irq_o, 1'b0);
    mdl_u.tok_wr(2'h2, 3'h3, 1'b0);
    xfer(2'h2, 15'h0003, 8'h00);
    chk8(rd, 8'h00);
    chk1(mdl_u.right_flag(3'h3), 1'b1);
    xfer(2'h3, 15'h0003, 8'h01);
    xfer(2'h2, 15'h0003, 8'h00);
    chk8(rd, 8'hff);
    chk1(mdl_u.right_flag(3'h3), 1'b0);
    xfer(2'h3, 15'h0003, 8'h00);
    mdl_u.tok_wr(2'h2, 3'h3, 1'b1);
    xfer(2'h2, 15'h0003, 8'h00);
    chk8(rd, 8'h00);
    mdl_u.right_select(15'h0012, 1'b1);
    xfer(2'h1, 15'h0012, 8'h11);
    chk1(co, 1'b1);
    xfer(2'h0, 15'h0012, 8'h00);
    chk8(rd, 8'ha5);
    mdl_u.right_select(15'h0013, 1'b1);
    xfer(2'h1, 15'h0012, 8'h66);
    chk1(co, 1'b0);
    mdl_u.right_select(15'h0013, 1'b0);
    inhibit_i <= 1'b1;
    xfer(2'h1, 15'h0012, 8'h99);
    chk1(co, 1'b1);
    chk1(sbusy_n, 1'b0);
    inhibit_i <= 1'b0;
    xfer(2'h0, 15'h0012, 8'h00);
    chk8(rd, 8'h66);
    conclude();
  end
endmodule // dpc_port_ctrl_tb
